// File: design/cnm_regs.svh
// Register map, reset values and field layout of the interrupt manager
`ifndef CNM_REGS_SVH
`define CNM_REGS_SVH
`define CNM_ADDR_NVEC 32'hFFFFFF20
`define CNM_ADDR_FVEC 32'hFFFFFF24
`define CNM_ADDR_RSVD 32'hFFFFFF28
`define CNM_ADDR_ROUTE 32'hFFFFFF2C
`define CNM_ADDR_PEND 32'hFFFFFF30
`define CNM_ADDR_MASK 32'hFFFFFF34
`define CNM_RST_VEC 8'h00
`define CNM_RST_WORD 32'h00000000
`define CNM_VEC_W 8
`define CNM_PROT_PRIV 0
`endif

// File: design/cnm_pkg.sv
// Types shared by the interrupt manager
package cnm_pkg;
    typedef logic [7:0] cnm_vec_t;
    typedef enum logic [2:0] {
        CNM_SEL_NONE = 3'b000,
        CNM_SEL_NVEC = 3'b001,
        CNM_SEL_FVEC = 3'b010,
        CNM_SEL_RSVD = 3'b011,
        CNM_SEL_ROUTE = 3'b100,
        CNM_SEL_PEND = 3'b101,
        CNM_SEL_MASK = 3'b110
    } cnm_sel_t;
endpackage

// File: design/cnm_central_interrupt_manager.sv
// Central interrupt manager: masking, class routing, priority and vector registers
//
// Operation
// - Thirty-two hardwired request inputs merge into one fast and one normal request.
// - A channel whose enable mask bit is clear never requests.
// - Each channel goes to the fast or normal class by its route bit.
// - Mask and route accept writes only from privileged accesses.
// - User-mode writes to mask or route are rejected and flag illegal access.
// - Fast and normal requests are evaluated independently and may coexist.
// - Per class the highest-numbered active unmasked channel wins.
// - Each class shows its winner in an 8-bit vector index.
// - Reading the fast vector index clears it.
// - Hardware never clears request flags; software must clear them.
// - A flag left set keeps the request asserted, forcing re-entry.
// - Normal vector index is 8 bits, read-only, reset zero.
// - Fast vector index is 8 bits, read-only, reset zero.
// - Route select is 32 bits, read-write, reset zero.
// - Pending location is 32 bits, read-write, reset zero, shows requests.
`timescale 1ns/1ps
`include "cnm_regs.svh"

module cnm_central_interrupt_manager
    import cnm_pkg::*;
#(
    parameter int NUM_CH = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [NUM_CH-1:0] i_chan_req,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [2:0] i_pprot,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_fast_req,
    output logic o_normal_req,
    output logic o_illegal_access
);

    generate
        if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_ch
            $error("NUM_CH must lie between 1 and 32");
        end
    endgenerate

    logic [31:0] route_reg;
    logic [31:0] mask_reg;
    logic [31:0] sw_pend_reg;
    cnm_vec_t nvec_reg;
    cnm_vec_t fvec_reg;
    logic fvec_full_reg;
    logic fvec_hold_reg;
    cnm_vec_t fvec_seen_reg;
    logic [31:0] prdata_reg;
    logic fast_req_reg;
    logic normal_req_reg;
    logic illegal_reg;

    logic [31:0] chan_in;
    logic [31:0] pend;
    logic [31:0] fast_act;
    logic [31:0] norm_act;
    logic fast_any;
    logic norm_any;
    cnm_vec_t fast_win;
    cnm_vec_t norm_win;
    cnm_sel_t sel;
    logic setup_rd;
    logic acc_wr;
    logic priv;
    logic wr_blocked;
    logic rd_fast;
    logic [31:0] rd_val;

    // Highest set bit wins; later loop passes overwrite lower ones
    function automatic cnm_vec_t top_index(input logic [31:0] v);
        cnm_vec_t idx;
        idx = `CNM_RST_VEC;
        for (int k = 0; k < 32; k++) begin
            if (v[k]) begin
                idx = cnm_vec_t'(k);
            end
        end
        return idx;
    endfunction

    // Unused high channels stay zero
    assign chan_in = 32'(i_chan_req);
    // Software-set bits join the wires; only software ever clears them
    assign pend = chan_in | sw_pend_reg;
    assign fast_act = pend & mask_reg & route_reg;
    assign norm_act = pend & mask_reg & ~route_reg;
    assign fast_any = |fast_act;
    assign norm_any = |norm_act;
    assign fast_win = top_index(fast_act);
    assign norm_win = top_index(norm_act);

    always_comb begin
        if (i_paddr == `CNM_ADDR_NVEC) begin
            sel = CNM_SEL_NVEC;
        end else if (i_paddr == `CNM_ADDR_FVEC) begin
            sel = CNM_SEL_FVEC;
        end else if (i_paddr == `CNM_ADDR_RSVD) begin
            sel = CNM_SEL_RSVD;
        end else if (i_paddr == `CNM_ADDR_ROUTE) begin
            sel = CNM_SEL_ROUTE;
        end else if (i_paddr == `CNM_ADDR_PEND) begin
            sel = CNM_SEL_PEND;
        end else if (i_paddr == `CNM_ADDR_MASK) begin
            sel = CNM_SEL_MASK;
        end else begin
            sel = CNM_SEL_NONE;
        end
    end

    always_comb begin
        case (sel)
            CNM_SEL_NVEC: rd_val = {24'h000000, nvec_reg};
            CNM_SEL_FVEC: rd_val = {24'h000000, fvec_reg};
            CNM_SEL_ROUTE: rd_val = route_reg;
            CNM_SEL_PEND: rd_val = pend;
            CNM_SEL_MASK: rd_val = mask_reg;
            default: rd_val = `CNM_RST_WORD;
        endcase
    end

    assign priv = i_pprot[`CNM_PROT_PRIV];
    // Read data and read side effects act at the setup edge so the cleared
    // fast index cannot be reloaded between capture and return
    assign setup_rd = i_psel && !i_penable && !i_pwrite;
    assign acc_wr = i_psel && i_penable && i_pwrite;
    assign rd_fast = setup_rd && (sel == CNM_SEL_FVEC);
    assign wr_blocked = (sel == CNM_SEL_ROUTE || sel == CNM_SEL_MASK) && !priv;

    // Zero-wait slave: every access completes in its first access cycle
    assign o_pready = i_psel && i_penable;
    assign o_pslverr = o_pready && ((sel == CNM_SEL_NONE) || (i_pwrite && wr_blocked));
    assign o_prdata = prdata_reg;
    assign o_fast_req = fast_req_reg;
    assign o_normal_req = normal_req_reg;
    assign o_illegal_access = illegal_reg;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg <= `CNM_RST_WORD;
        end else if (setup_rd) begin
            prdata_reg <= rd_val;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            route_reg <= `CNM_RST_WORD;
        end else if (acc_wr && sel == CNM_SEL_ROUTE && priv) begin
            route_reg <= i_pwdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_reg <= `CNM_RST_WORD;
        end else if (acc_wr && sel == CNM_SEL_MASK && priv) begin
            mask_reg <= i_pwdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sw_pend_reg <= `CNM_RST_WORD;
        end else if (acc_wr && sel == CNM_SEL_PEND) begin
            sw_pend_reg <= i_pwdata;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            illegal_reg <= 1'b0;
        end else begin
            illegal_reg <= acc_wr && wr_blocked;
        end
    end

    // Both lines are computed side by side; neither suppresses the other
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fast_req_reg <= 1'b0;
            normal_req_reg <= 1'b0;
        end else begin
            fast_req_reg <= fast_any;
            normal_req_reg <= norm_any;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            nvec_reg <= `CNM_RST_VEC;
        end else if (norm_any) begin
            nvec_reg <= norm_win;
        end else begin
            nvec_reg <= `CNM_RST_VEC;
        end
    end

    // After a read clears the fast index it stays clear until the fast
    // request drops or its winner changes, so a repeated read in one
    // service routine cannot return the same index twice
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fvec_hold_reg <= 1'b0;
            fvec_seen_reg <= `CNM_RST_VEC;
        end else if (rd_fast && fvec_full_reg) begin
            fvec_hold_reg <= 1'b1;
            fvec_seen_reg <= fvec_reg;
        end else if (!fast_any || fast_win != fvec_seen_reg) begin
            fvec_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fvec_reg <= `CNM_RST_VEC;
            fvec_full_reg <= 1'b0;
        end else if (rd_fast && fvec_full_reg) begin
            fvec_reg <= `CNM_RST_VEC;
            fvec_full_reg <= 1'b0;
        end else if (!fvec_full_reg && fast_any && !fvec_hold_reg) begin
            fvec_reg <= fast_win;
            fvec_full_reg <= 1'b1;
        end else if (fvec_full_reg && !fast_any) begin
            fvec_reg <= `CNM_RST_VEC;
            fvec_full_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    chk_mask_gate_off: assert property (
        (mask_reg == `CNM_RST_WORD) |=> (!o_fast_req && !o_normal_req))
        else $error("request raised with all channels masked");

    chk_route_fast_class: assert property (
        (|(pend & mask_reg & route_reg)) |=> o_fast_req)
        else $error("fast-routed channel did not raise fast request");

    chk_route_normal_class: assert property (
        (|(pend & mask_reg & ~route_reg)) |=> o_normal_req)
        else $error("normal-routed channel did not raise normal request");

    chk_user_write_blocked: assert property (
        (acc_wr && !priv && sel == CNM_SEL_MASK) |=> $stable(mask_reg))
        else $error("user-mode write changed the mask");

    chk_illegal_signalled: assert property (
        (acc_wr && wr_blocked) |-> o_pslverr ##1 o_illegal_access)
        else $error("rejected write not signalled");

    chk_both_classes_live: assert property (
        (fast_any && norm_any) |=> (o_fast_req && o_normal_req))
        else $error("classes not evaluated independently");

    chk_winner_highest: assert property (
        norm_any |-> ((norm_act >> norm_win) == 32'h00000001))
        else $error("normal winner is not the highest active channel");

    chk_normal_index_value: assert property (
        norm_any |=> (nvec_reg == $past(norm_win)))
        else $error("normal index differs from winning channel");

    chk_fast_index_value: assert property (
        (!fvec_full_reg && fast_any && !fvec_hold_reg) |=> (fvec_reg == $past(fast_win)))
        else $error("fast index differs from winning channel");

    chk_fast_read_clears: assert property (
        (rd_fast && fvec_full_reg) |=> (fvec_reg == `CNM_RST_VEC) && !fvec_full_reg)
        else $error("fast index not cleared by read");

    chk_request_persists: assert property (
        (fast_any && $past(fast_any)) |=> o_fast_req [*1])
        else $error("request dropped while flag still set");

    chk_route_write_lands: assert property (
        (acc_wr && priv && sel == CNM_SEL_ROUTE) |=> (route_reg == $past(i_pwdata)))
        else $error("privileged route write not stored");

    cov_both_classes: cover property (o_fast_req && o_normal_req);
    cov_user_reject: cover property (acc_wr && wr_blocked);
    cov_fast_read: cover property (rd_fast && fvec_full_reg ##1 !fvec_full_reg);
    cov_top_channel: cover property (fast_any && fast_win == 8'h1F);

endmodule

// File: bench/cnm_core_model.sv
// Processor core model: takes the fast class ahead of the normal class
`timescale 1ns/1ps
module cnm_core_model (
    input wire logic i_fast_req,
    input wire logic i_normal_req,
    output logic [1:0] o_serving
);
    // Purely combinational, so the bench sees the choice in the same cycle
    assign o_serving = i_fast_req ? 2'b10 : (i_normal_req ? 2'b01 : 2'b00);
endmodule

// File: bench/cnm_central_interrupt_manager_test.sv
// Self-checking bench for the interrupt manager
`timescale 1ns/1ps
`include "cnm_regs.svh"
module cnm_central_interrupt_manager_test import cnm_pkg::*;;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, chan_req = 0, prdata, rd, msk, rte, act;
    logic [2:0] pprot = 0;
    logic pready, pslverr, fast_req, normal_req, illegal, er, ill;
    logic [1:0] serving;
    logic [31:0] addrs [5] = '{`CNM_ADDR_NVEC, `CNM_ADDR_FVEC, `CNM_ADDR_ROUTE,
        `CNM_ADDR_PEND, `CNM_ADDR_MASK};
    int err_count = 0, cmp_count = 0;

    always #5 sys_clk = ~sys_clk;

    cnm_central_interrupt_manager dut (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_chan_req(chan_req), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pprot(pprot), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_fast_req(fast_req),
        .o_normal_req(normal_req), .o_illegal_access(illegal));
    cnm_core_model core (.i_fast_req(fast_req), .i_normal_req(normal_req),
        .o_serving(serving));

    // Highest set bit, zero when none is set
    function automatic logic [31:0] win(input logic [31:0] v);
        win = 0;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) win = i;
        end
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    // One APB transfer; the closing edge keeps the next setup off this time step
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [2:0] p);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= p;
        @(posedge sys_clk) penable <= 1;
        // No wait limit here: only the watchdog may end a stalled access
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
        ill = illegal;
    endtask

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(61));
        repeat (4) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        foreach (addrs[i]) begin
            apb(0, addrs[i], 0, 3'h1);
            chk("reset value", 32'h0, rd);
            chk("reset err", 32'h0, er);
        end
        apb(0, 32'hFFFFFF38, 0, 3'h1);
        chk("unmapped err", 32'h1, er);
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
        for (int i = 2; i < 5; i += 2) begin
            apb(1, addrs[i], 32'hFFFFFFFF, 3'h0);
            chk("user write err", 32'h1, er);
            chk("user write pulse", 32'h1, ill);
            apb(0, addrs[i], 0, 3'h1);
            chk("user write kept out", 32'h0, rd);
        end
        apb(1, `CNM_ADDR_PEND, 32'h00000100, 3'h1);
        apb(0, `CNM_ADDR_PEND, 0, 3'h1);
        chk("pending readback", 32'h00000100, rd);
        chk("masked request", 32'h0, fast_req | normal_req);
        apb(1, `CNM_ADDR_PEND, 0, 3'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1, addrs[i], 32'hFFFFFFFF, 3'h1);
            chk("index write err", 32'h0, er);
            apb(0, addrs[i], 0, 3'h1);
            chk("index not writable", 32'h0, rd);
        end
        $display("test privilege done");
        for (int k = 0; k < 10; k++) begin
            msk = (k == 0) ? 32'hFFFFFFFF : $urandom;
            rte = (k == 0) ? 32'h80000001 : $urandom;
            apb(1, `CNM_ADDR_MASK, msk, 3'h1);
            apb(1, `CNM_ADDR_ROUTE, rte, 3'h1);
            chan_req <= (k == 0) ? 32'hFFFFFFFF : $urandom;
            repeat (3) @(posedge sys_clk);
            act = chan_req & msk;
            chk("fast req", |(act & rte), fast_req);
            chk("normal req", |(act & ~rte), normal_req);
            apb(0, `CNM_ADDR_NVEC, 0, 3'h1);
            chk("normal index", win(act & ~rte), rd);
            apb(0, `CNM_ADDR_FVEC, 0, 3'h1);
            chk("fast index", win(act & rte), rd);
            apb(0, `CNM_ADDR_FVEC, 0, 3'h1);
            chk("fast index cleared", 32'h0, rd);
            chk("request held", |(act & rte), fast_req);
            if (fast_req === 1'b1 && normal_req === 1'b1) begin
                chk("core order", 32'h2, serving);
            end
            chan_req <= 0;
            repeat (3) @(posedge sys_clk);
            chk("request drop", 32'h0, fast_req | normal_req);
        end
        $display("test routing done");
        report_and_stop();
    end
endmodule
